// file: hw/bif_pkg.sv
// Constants and types for the bridge interrupt forwarding block.
// Assumes one 50 MHz clock domain and an asynchronous active-low reset.
package bif_pkg;
  localparam int unsigned NUM_LINES   = 4;
  localparam int unsigned ADDR_W      = 64;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned CTRL_MSI_EN = 16;
  localparam logic [11:0] CTRL_OFFSET = 12'h0f0;
  localparam logic [3:0]  PINS_IDLE   = 4'hf;

  typedef enum logic [2:0] {
    BIF_MSG_ASSERT_A,
    BIF_MSG_ASSERT_B,
    BIF_MSG_ASSERT_C,
    BIF_MSG_ASSERT_D,
    BIF_MSG_DEASSERT_A,
    BIF_MSG_DEASSERT_B,
    BIF_MSG_DEASSERT_C,
    BIF_MSG_DEASSERT_D
  } bif_msg_t;
endpackage

// file: hw/bif_edge_queue.sv
// Per-line pending message tracker for forward mode.
// Assumes sampled pin levels arrive already synchronised to clk_i.
`timescale 1ns/100ps
module bif_edge_queue #(
  parameter int unsigned LINES = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             en_i,
  input  wire logic             clear_i,
  input  wire logic [LINES-1:0] level_i,
  input  wire logic [LINES-1:0] take_i,
  output logic      [LINES-1:0] pend_o,
  output logic      [LINES-1:0] want_o
);
  typedef struct packed {
    logic [LINES-1:0] sent;
    logic [LINES-1:0] pend;
  } bif_eq_state_t;
  bif_eq_state_t s_reg;
  bif_eq_state_t s_next;

  // A line is pending whenever its active level differs from what was reported
  always_comb begin
    s_next = s_reg;
    if (clear_i) begin
      s_next = '0;
    end else begin
      s_next.sent = s_reg.sent ^ (take_i & s_reg.pend);
      s_next.pend = level_i ^ s_next.sent;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '0;
    end else if (en_i) begin
      s_reg <= s_next;
    end
  end

  assign pend_o = s_reg.pend;
  assign want_o = ~s_reg.sent;
endmodule

// file: hw/bif_top.sv
// Interrupt forwarding between the serial link and the PCI side of the bridge.
// Assumes pins and strap come from outside and are synchronised here; the link
// message port and the message-signaled write port are same-clock logic.
// The direction strap is caught once per reset, after it has settled.
`timescale 1ns/100ps
module bif_top (
  input  wire logic                         clk_i,
  input  wire logic                         rst_n_i,
  input  wire logic                         ce_i,
  input  wire logic                         bridge_direction_strap_i,
  input  wire logic                         pci_rst_n_i,
  input  wire logic                         msi_enable_i,
  input  wire logic [bif_pkg::ADDR_W-1:0]   msi_addr_i,
  input  wire logic [bif_pkg::DATA_W-1:0]   msi_data_i,
  input  wire logic                         pci_msi_valid_i,
  input  wire logic [1:0]                   pci_msi_line_i,
  input  wire logic [bif_pkg::NUM_LINES-1:0] pci_int_n_i,
  output logic      [bif_pkg::NUM_LINES-1:0] pci_int_n_o,
  output logic      [bif_pkg::NUM_LINES-1:0] pci_int_oe_n_o,
  output logic                              msi_wr_valid_o,
  output logic      [bif_pkg::ADDR_W-1:0]   msi_wr_addr_o,
  output logic      [bif_pkg::DATA_W-1:0]   msi_wr_data_o,
  input  wire logic                         msi_wr_ready_i,
  input  wire logic                         link_rx_valid_i,
  input  wire bif_pkg::bif_msg_t            link_rx_msg_i,
  output logic                              link_tx_valid_o,
  output bif_pkg::bif_msg_t                 link_tx_msg_o,
  input  wire logic                         link_tx_ready_i,
  output logic                              reverse_mode_o
);
  import bif_pkg::*;

  typedef struct packed {
    logic [1:0]           strap_sync;
    logic [1:0]           prst_sync;
    logic [NUM_LINES-1:0] pin_sync0;
    logic [NUM_LINES-1:0] pin_sync1;
    logic                 reverse;
    logic                 mode_known;
    logic [1:0]           settle;
    logic [NUM_LINES-1:0] line_active;
    logic [NUM_LINES-1:0] int_n;
    logic [NUM_LINES-1:0] int_oe_n;
    logic                 wr_valid;
    logic [ADDR_W-1:0]    wr_addr;
    logic [DATA_W-1:0]    wr_data;
    logic                 tx_valid;
    bif_msg_t             tx_msg;
  } bif_state_t;
  bif_state_t s_reg;
  bif_state_t s_next;

  // Forward-mode pin edge bookkeeping
  logic [NUM_LINES-1:0] fwd_level;
  logic [NUM_LINES-1:0] fwd_pend;
  logic [NUM_LINES-1:0] fwd_want;
  logic [NUM_LINES-1:0] fwd_take;
  logic                 fwd_clear;
  logic                 fwd_pick_ok;
  logic [1:0]           fwd_pick;
  bif_msg_t             fwd_msg;

  // Handshake and decode helpers
  logic                 msi_busy;
  logic                 tx_free;
  logic                 prst_active;
  logic                 pins_off;
  logic                 rx_take;
  logic                 rx_release;
  logic [1:0]           rx_line;
  logic                 msi_fwd_go;
  bif_msg_t             msi_msg;

  // Message kind for a line and direction
  function automatic bif_msg_t msg_of(input logic [1:0] line, input logic assert_e);
    msg_of = bif_msg_t'({~assert_e, line});
  endfunction

  // Line letter carried by a message
  function automatic logic [1:0] line_of(input bif_msg_t m);
    line_of = m[1:0];
  endfunction

  // True for the four deassert kinds
  function automatic logic is_release(input bif_msg_t m);
    is_release = m[2];
  endfunction

  assign msi_busy    = s_reg.wr_valid && !msi_wr_ready_i;
  assign tx_free     = !s_reg.tx_valid || link_tx_ready_i;
  assign prst_active = !s_reg.prst_sync[1];
  assign pins_off    = msi_enable_i || prst_active;
  // Forward mode tracks pins (active low) unless the PCI side uses MSI writes
  assign fwd_level   = msi_enable_i ? '0 : ~s_reg.pin_sync1;
  assign fwd_clear   = s_reg.reverse || !s_reg.mode_known || msi_enable_i;
  assign fwd_msg     = msg_of(fwd_pick, fwd_want[fwd_pick]);
  assign msi_fwd_go  = msi_enable_i && pci_msi_valid_i;
  assign msi_msg     = msg_of(pci_msi_line_i, 1'b1);

  // A received message is taken only in reverse mode while the write slot is open
  assign rx_take     = s_reg.mode_known && s_reg.reverse && link_rx_valid_i && !msi_busy;
  assign rx_release  = is_release(link_rx_msg_i);
  assign rx_line     = line_of(link_rx_msg_i);

  // Lowest pending line wins the link slot
  always_comb begin
    fwd_pick_ok = 1'b0;
    fwd_pick    = 2'h0;
    for (int i = NUM_LINES - 1; i >= 0; i--) begin
      if (fwd_pend[i]) begin
        fwd_pick_ok = 1'b1;
        fwd_pick    = i[1:0];
      end
    end
  end

  always_comb begin
    s_next   = s_reg;
    fwd_take = '0;
    // Two-stage synchronisers; only the second stage is read
    s_next.strap_sync = {s_reg.strap_sync[0], bridge_direction_strap_i};
    s_next.prst_sync  = {s_reg.prst_sync[0], pci_rst_n_i};
    s_next.pin_sync0  = pci_int_n_i;
    s_next.pin_sync1  = s_reg.pin_sync0;
    s_next.settle     = {s_reg.settle[0], 1'b1};

    // Direction caught once, after the strap has crossed both sync stages;
    // an earlier catch would read the synchroniser's reset value
    if (!s_reg.mode_known && s_reg.settle[1]) begin
      s_next.reverse    = s_reg.strap_sync[1];
      s_next.mode_known = 1'b1;
    end

    // Accepted handshakes free their slots; a request below may refill them
    if (link_tx_ready_i) begin
      s_next.tx_valid = 1'b0;
    end
    if (msi_wr_ready_i) begin
      s_next.wr_valid = 1'b0;
    end

    if (s_reg.mode_known && s_reg.reverse) begin
      // Link messages drive same-lettered pins or become MSI writes
      if (rx_take) begin
        if (!rx_release && msi_enable_i) begin
          s_next.wr_valid = 1'b1;
          s_next.wr_addr  = msi_addr_i;
          s_next.wr_data  = msi_data_i | {{(DATA_W-2){1'b0}}, rx_line};
        end
        s_next.line_active[rx_line] = !rx_release;
      end

      // Pins follow the line state unless MSI owns interrupts or PCI is in reset
      if (pins_off) begin
        s_next.int_oe_n = PINS_IDLE;
        s_next.int_n    = PINS_IDLE;
      end else begin
        s_next.int_n    = ~s_next.line_active;
        s_next.int_oe_n = ~s_next.line_active; // Open-drain: drive low only
      end
      // Line A state is dropped so it does not come back after PCI reset
      if (prst_active) begin
        s_next.line_active[0] = 1'b0;
      end
    end else begin
      // Forward mode: an MSI from the PCI side beats pin edges for the link slot
      s_next.int_n       = PINS_IDLE;
      s_next.int_oe_n    = PINS_IDLE;
      s_next.line_active = '0;
      // An MSI pulse that meets a busy slot is lost; pin edges wait in the tracker
      if (s_reg.mode_known && tx_free) begin
        if (msi_fwd_go) begin
          s_next.tx_valid = 1'b1;
          s_next.tx_msg   = msi_msg;
        end else if (fwd_pick_ok) begin
          s_next.tx_valid = 1'b1;
          s_next.tx_msg   = fwd_msg;
          fwd_take[fwd_pick] = 1'b1;
        end
      end
    end
  end

  // All state, synchronisers included, freezes while ce_i is low
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg          <= '0;
      s_reg.pin_sync0 <= PINS_IDLE;
      s_reg.pin_sync1 <= PINS_IDLE;
      s_reg.int_n    <= PINS_IDLE;
      s_reg.int_oe_n <= PINS_IDLE;
      s_reg.tx_msg   <= BIF_MSG_ASSERT_A;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  // Per-line edge bookkeeping for forward mode
  bif_edge_queue #(
    .LINES (NUM_LINES)
  ) u_edge (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .en_i    (ce_i),
    .clear_i (fwd_clear),
    .level_i (fwd_level),
    .take_i  (fwd_take),
    .pend_o  (fwd_pend),
    .want_o  (fwd_want)
  );

  // Outputs are register fields, never combinational
  assign pci_int_n_o     = s_reg.int_n;
  assign pci_int_oe_n_o  = s_reg.int_oe_n;
  assign msi_wr_valid_o  = s_reg.wr_valid;
  assign msi_wr_addr_o   = s_reg.wr_addr;
  assign msi_wr_data_o   = s_reg.wr_data;
  assign link_tx_valid_o = s_reg.tx_valid;
  assign link_tx_msg_o   = s_reg.tx_msg;
  assign reverse_mode_o  = s_reg.reverse;
endmodule

// file: sim/bif_checker.sv
// Port checker for bif_top.
// Assumes ce_i held high; bound from the bench by name.
`timescale 1ns/100ps
module bif_checker (
  input wire logic              clk_i,
  input wire logic              rst_n_i,
  input wire logic              pci_rst_n_i,
  input wire logic              msi_enable_i,
  input wire logic              link_rx_valid_i,
  input wire bif_pkg::bif_msg_t link_rx_msg_i,
  input wire logic [3:0]        pci_int_n_o,
  input wire logic [3:0]        pci_int_oe_n_o,
  input wire logic              msi_wr_valid_o,
  input wire logic              msi_wr_ready_i,
  input wire logic [15:0]       msi_wr_data_o,
  input wire logic              link_tx_valid_o,
  input wire logic              link_tx_ready_i,
  input wire bif_pkg::bif_msg_t link_tx_msg_o,
  input wire logic              pci_msi_valid_i,
  input wire logic [1:0]        pci_msi_line_i,
  input wire logic              reverse_mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire ok = !(msi_wr_valid_o && !msi_wr_ready_i);
  wire rx = reverse_mode_o && link_rx_valid_i && !msi_enable_i && pci_rst_n_i && ok;
  wire rm = reverse_mode_o && link_rx_valid_i && msi_enable_i && pci_rst_n_i && !msi_wr_valid_o;
  pin_set_a: assert property (rx && !link_rx_msg_i[2] && $past(pci_rst_n_i, 3)
    |=> !pci_int_n_o[$past(link_rx_msg_i[1:0])]) else $error("pin not driven");
  pin_clear_a: assert property (rx && link_rx_msg_i[2]
    |=> pci_int_oe_n_o[$past(link_rx_msg_i[1:0])]) else $error("pin not released");
  msi_pins_a: assert property (msi_enable_i && $past(msi_enable_i)
    |-> pci_int_oe_n_o == 4'hf) else $error("pins driven with msi");
  msi_write_a: assert property (rm && !link_rx_msg_i[2] |=> msi_wr_valid_o
    && msi_wr_data_o[1:0] == $past(link_rx_msg_i[1:0])) else $error("msi write wrong");
  msi_none_a: assert property (rm && link_rx_msg_i[2]
    |=> !msi_wr_valid_o) else $error("msi from deassert");
  msi_hold_a: assert property (msi_wr_valid_o && !msi_wr_ready_i
    |=> msi_wr_valid_o && $stable(msi_wr_data_o)) else $error("msi write dropped");
  tx_hold_a: assert property (link_tx_valid_o && !link_tx_ready_i
    |=> link_tx_valid_o && $stable(link_tx_msg_o)) else $error("link msg dropped");
  fwd_msi_a: assert property (!reverse_mode_o && pci_msi_valid_i && !link_tx_valid_o
    |=> link_tx_valid_o && link_tx_msg_o == {1'b0, $past(pci_msi_line_i)})
    else $error("msi not forwarded");
  reset_line_a: assert property ((reverse_mode_o && !pci_rst_n_i) [*4]
    |-> pci_int_oe_n_o[0]) else $error("line a driven in reset");
  tx_reverse_a: assert property (reverse_mode_o |-> !link_tx_valid_o)
    else $error("link msg in reverse");
endmodule

// file: sim/bif_far_model.sv
// Far side: link receiver and MSI target that stall at random.
// Assumes the bench records the handshakes itself.
`timescale 1ns/100ps
module bif_far_model (
  input  wire logic clk_i,
  output logic      link_tx_ready_o,
  output logic      msi_wr_ready_o
);
  integer seed = 13754;
  initial link_tx_ready_o = 1'b0;
  initial msi_wr_ready_o = 1'b0;
  always @(negedge clk_i) begin
    link_tx_ready_o <= ($random(seed) % 3) != 0;
    msi_wr_ready_o  <= ($random(seed) % 2) != 0;
  end
endmodule

// file: sim/bif_top_tb.sv
// Bench for bif_top: forward pins and MSI, reverse pins, MSI writes, PCI reset.
// Assumes bif_checker and bif_far_model are compiled before it.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module bif_top_tb;
  import bif_pkg::*;
  logic clk_i = 0, rst_n_i = 0, ce_i = 1, bridge_direction_strap_i = 0, pci_rst_n_i = 1;
  logic msi_enable_i = 0, pci_msi_valid_i = 0, link_rx_valid_i = 0;
  logic msi_wr_ready_i, link_tx_ready_i, msi_wr_valid_o, link_tx_valid_o, reverse_mode_o;
  logic [1:0] pci_msi_line_i = 0;
  logic [3:0] pci_int_n_i = 4'hf, pci_int_n_o, pci_int_oe_n_o, ep;
  logic [63:0] msi_addr_i = 0, msi_wr_addr_o, wa;
  logic [15:0] msi_data_i = 0, msi_wr_data_o, wd;
  bif_msg_t link_rx_msg_i = BIF_MSG_ASSERT_A, link_tx_msg_o, txq[$];
  integer seed = 13754, n_mismatch = 0, tests_run = 0, nw = 0, i, k, t;
  bif_top bif_top_inst (.*);
  bif_far_model bif_far_model_inst (.clk_i(clk_i), .link_tx_ready_o(link_tx_ready_i),
    .msi_wr_ready_o(msi_wr_ready_i));
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (link_tx_valid_o && link_tx_ready_i) txq.push_back(link_tx_msg_o);
    if (msi_wr_valid_o && msi_wr_ready_i) begin
      nw++;
      wa = msi_wr_addr_o;
      wd = msi_wr_data_o;
    end
  end
  function automatic bif_msg_t msg_of(input logic [1:0] ln, input logic lvl);
    return bif_msg_t'({lvl, ln});
  endfunction
  task automatic final_report;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic get_msg(input bif_msg_t e);
    bif_msg_t got;
    for (t = 0; t < 50 && txq.size() == 0; t++) cyc(1);
    if (txq.size() == 0) begin
      n_mismatch++;
      final_report();
    end else begin
      got = txq.pop_front();
      `CHK("link msg", e, got)
    end
  endtask
  task automatic send(input bif_msg_t m);
    link_rx_msg_i = m;
    link_rx_valid_i = 1;
    cyc(1);
    link_rx_valid_i = 0;
  endtask
  task automatic do_reset(input logic dir);
    rst_n_i = 0;
    bridge_direction_strap_i = dir;
    cyc(3);
    rst_n_i = 1;
    cyc(4);
    `CHK("direction", dir, reverse_mode_o)
  endtask
  initial begin
    do_reset(0);
    pci_int_n_i = 4'hc;
    get_msg(BIF_MSG_ASSERT_A);
    get_msg(BIF_MSG_ASSERT_B);
    for (i = 0; i < 24; i++) begin
      k = $random(seed) & 3;
      pci_int_n_i[k] = ~pci_int_n_i[k];
      get_msg(msg_of(k[1:0], pci_int_n_i[k]));
    end
    cyc(10);
    `CHK("extra msgs", 0, txq.size())
    msi_enable_i = 1;
    for (i = 0; i < 4; i++) begin
      pci_msi_line_i = i[1:0];
      pci_msi_valid_i = 1;
      cyc(1);
      pci_msi_valid_i = 0;
      get_msg(msg_of(i[1:0], 1'b0));
    end
    msi_enable_i = 0;
    do_reset(1);
    ep = 4'hf;
    for (i = 0; i < 16; i++) begin
      k = (i < 8) ? i : $random(seed) & 7;
      send(bif_msg_t'(k[2:0]));
      ep[k[1:0]] = k[2];
      cyc(1);
      `CHK("pins", ep, pci_int_n_o)
      `CHK("pin enables", ep, pci_int_oe_n_o)
    end
    send(BIF_MSG_ASSERT_D);
    msi_enable_i = 1;
    msi_addr_i = {$random(seed), $random(seed)};
    msi_data_i = 16'($random(seed)) & 16'hfffc;
    cyc(2);
    `CHK("pins off", 4'hf, pci_int_oe_n_o)
    send(BIF_MSG_DEASSERT_B);
    send(BIF_MSG_ASSERT_C);
    for (t = 0; t < 20 && nw == 0; t++) cyc(1);
    if (nw == 0) begin
      n_mismatch++;
      final_report();
    end
    cyc(4);
    `CHK("writes", 1, nw)
    `CHK("msi addr", msi_addr_i, wa)
    `CHK("msi data", msi_data_i | 16'h0002, wd)
    msi_enable_i = 0;
    send(BIF_MSG_ASSERT_A);
    pci_rst_n_i = 0;
    cyc(5);
    `CHK("line a", 2'b11, {pci_int_n_o[0], pci_int_oe_n_o[0]})
    pci_rst_n_i = 1;
    cyc(5);
    `CHK("pins after reset", 4'h3, pci_int_n_o)
    final_report();
  end
endmodule
bind bif_top bif_checker bif_checker_inst (.*);
